// ==== bcc_chain.sv ====
`timescale 1ns/10ps
module bcc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         wclk,
   input  wire logic         wrst_n,
   input  wire logic         w_valid,
   output logic              w_ready,
   input  wire logic [W-1:0] w_data,
   input  wire logic         rclk,
   input  wire logic         rrst_n,
   output logic              r_valid,
   input  wire logic         r_ready,
   output logic [W-1:0]      r_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wb_q, wb_d, wg_q, rg1_q, rg2_q, rb_q, rb_d, rg_q, wg1_q, wg2_q;

   function automatic logic [AW:0] b2g(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // Full compares against the read pointer seen through two flops.
   always_comb begin
      w_ready = wg_q != {~rg2_q[AW:AW-1], rg2_q[AW-2:0]};
      wb_d = wb_q + ((w_valid && w_ready) ? 1'b1 : 1'b0);
      r_valid = rg_q != wg2_q;
      rb_d = rb_q + ((r_valid && r_ready) ? 1'b1 : 1'b0);
      r_data = mem[rb_q[AW-1:0]];
   end

   // Write side runs on the link clock.
   always_ff @(posedge wclk or negedge wrst_n) begin
      if (!wrst_n) begin
         wb_q  <= '0;
         wg_q  <= '0;
         rg1_q <= '0;
         rg2_q <= '0;
      end else begin
         wb_q  <= wb_d;
         wg_q  <= b2g(wb_d);
         rg1_q <= rg_q;
         rg2_q <= rg1_q;
      end
   end

   // Storage has no reset; the pointers guard against reading stale words.
   always_ff @(posedge wclk) begin
      if (w_valid && w_ready) begin
         mem[wb_q[AW-1:0]] <= w_data;
      end
   end

   // Read side runs on the system clock.
   always_ff @(posedge rclk or negedge rrst_n) begin
      if (!rrst_n) begin
         rb_q  <= '0;
         rg_q  <= '0;
         wg1_q <= '0;
         wg2_q <= '0;
      end else begin
         rb_q  <= rb_d;
         rg_q  <= b2g(rb_d);
         wg1_q <= wg_q;
         wg2_q <= wg1_q;
      end
   end
endmodule // bcc_fifo

module bcc_chain #(
   parameter int          N_IN    = bcc_pkg::N_IN_DEF,
   parameter int          N_IO    = bcc_pkg::N_IO_DEF,
   parameter int          N_MC    = bcc_pkg::N_MC_DEF,
   parameter logic [31:0] ID      = bcc_pkg::ID_DEF,
   parameter bit          JTAG_EN = 1'b1,
   parameter bit          PULL_EN = 1'b1
) (
   input  wire logic            clk,
   input  wire logic            arst_n,
   input  wire logic            tck,
   input  wire logic            tms,
   input  wire logic            tdi,
   output logic                 tdo,
   output logic                 tdo_oe,
   output logic                 tms_pull_en,
   output logic                 tdi_pull_en,
   input  wire logic            user_tdo,
   input  wire logic            user_tdo_oe,
   input  wire logic [N_IN-1:0] in_pin,
   input  wire logic [N_IO-1:0] io_in,
   input  wire logic [N_IO-1:0] core_out,
   input  wire logic [N_IO-1:0] core_oe,
   output logic [N_IO-1:0]      io_out,
   output logic [N_IO-1:0]      io_oe,
   input  wire logic [N_MC-1:0] mc_core,
   output logic [N_MC-1:0]      mc_out,
   input  wire logic            upd_hold
);
   import bcc_pkg::*;
   localparam int MB = N_IN + CELL_CAP * N_IO;
   localparam int CL = MB + N_MC;
   localparam int UW = CELL_UPD * N_IO + N_MC;

   logic          rs1_q, rs2_q, rst_t_n;
   bcc_tap_type   st_q, st_d;
   logic [IR_W-1:0] irs_q, irs_d, ir_q, ir_d;
   logic [CL-1:0] src, sy1_q, sy2_q, cap_q, cap_d;
   logic [UW-1:0] cu, upd_q, upd_d, ovr_q, ovr_d, f_data;
   logic [31:0]   idr_q, idr_d;
   logic          byp_q, byp_d, pend_q, pend_d, w_ready, f_valid;
   logic          tdo_q, tdo_d, ten_q, ten_d, bnd, idsel, ext_q, ext_d, ex1_q, ex2_q;
   logic [N_IO-1:0] out_q, out_d, oe_q, oe_d;
   logic [N_MC-1:0] mc_q, mc_d;

   // Power-up reset reaches the link domain with a synchronous release.
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   assign rst_t_n = rs2_q && JTAG_EN;

   // Cell layout: input cells, then three stages per I/O cell, then one per macrocell.
   always_comb begin
      src = '0;
      cu  = '0;
      for (int i = 0; i < N_IN; i++) begin
         src[i] = in_pin[i];
      end
      for (int i = 0; i < N_IO; i++) begin
         src[N_IN+3*i]   = io_in[i];
         src[N_IN+3*i+1] = core_out[i];
         src[N_IN+3*i+2] = core_oe[i];
         cu[i]           = cap_q[N_IN+3*i+1];
         cu[N_IO+i]      = cap_q[N_IN+3*i+2];
      end
      for (int j = 0; j < N_MC; j++) begin
         src[MB+j]       = mc_core[j];
         cu[2*N_IO+j]    = cap_q[MB+j];
      end
   end

   // Live values cross from pins and other clocks through two flops; bits are not coherent.
   always_ff @(posedge tck or negedge rst_t_n) begin
      if (!rst_t_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
      end else begin
         sy1_q <= src;
         sy2_q <= sy1_q;
      end
   end

   // Controller next state and every cell control are made here.
   always_comb begin
      bnd    = ir_q == IR_EXTEST || ir_q == IR_SAMPLE;
      idsel  = ir_q == IR_IDCODE;
      st_d   = st_q;
      irs_d  = irs_q;
      ir_d   = ir_q;
      cap_d  = cap_q;
      upd_d  = upd_q;
      idr_d  = idr_q;
      byp_d  = byp_q;
      pend_d = (pend_q && !w_ready) || (st_q == UPD_DR && bnd);
      case (st_q)
         TLR:    st_d = tms ? TLR : RTI;
         RTI:    st_d = tms ? SEL_DR : RTI;
         SEL_DR: st_d = tms ? SEL_IR : CAP_DR;
         CAP_DR: st_d = tms ? EX1_DR : SH_DR;
         SH_DR:  st_d = tms ? EX1_DR : SH_DR;
         EX1_DR: st_d = tms ? UPD_DR : PA_DR;
         PA_DR:  st_d = tms ? EX2_DR : PA_DR;
         EX2_DR: st_d = tms ? UPD_DR : SH_DR;
         UPD_DR: st_d = tms ? SEL_DR : RTI;
         SEL_IR: st_d = tms ? TLR : CAP_IR;
         CAP_IR: st_d = tms ? EX1_IR : SH_IR;
         SH_IR:  st_d = tms ? EX1_IR : SH_IR;
         EX1_IR: st_d = tms ? UPD_IR : PA_IR;
         PA_IR:  st_d = tms ? EX2_IR : PA_IR;
         EX2_IR: st_d = tms ? UPD_IR : SH_IR;
         UPD_IR: st_d = tms ? SEL_DR : RTI;
         default: st_d = TLR;
      endcase
      case (st_q)
         TLR: ir_d = IR_RST;
         CAP_IR: irs_d = IR_CAPVAL;
         SH_IR: irs_d = {tdi, irs_q[IR_W-1:1]};
         UPD_IR: ir_d = irs_q;
         CAP_DR: begin
            byp_d = 1'b0;
            if (bnd) cap_d = sy2_q;
            if (idsel) idr_d = ID;
         end
         SH_DR: begin
            byp_d = tdi;
            if (bnd) cap_d = {tdi, cap_q[CL-1:1]};
            if (idsel) idr_d = {tdi, idr_q[31:1]};
         end
         UPD_DR: if (bnd) upd_d = cu;
         default: ;
      endcase
      tdo_d = byp_q;
      if (st_q == SH_IR) tdo_d = irs_q[0];
      else if (bnd) tdo_d = cap_q[0];
      else if (idsel) tdo_d = idr_q[0];
      ten_d = st_q == SH_DR || st_q == SH_IR;
      ext_d = ir_d == IR_EXTEST;
   end

   // Controller and chain registers on the rising link clock edge.
   always_ff @(posedge tck or negedge rst_t_n) begin
      if (!rst_t_n) begin
         st_q   <= TLR;
         irs_q  <= IR_RST;
         ir_q   <= IR_RST;
         cap_q  <= '0;
         upd_q  <= '0;
         idr_q  <= '0;
         byp_q  <= 1'b0;
         pend_q <= 1'b0;
         ext_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         irs_q  <= irs_d;
         ir_q   <= ir_d;
         cap_q  <= cap_d;
         upd_q  <= upd_d;
         idr_q  <= idr_d;
         byp_q  <= byp_d;
         pend_q <= pend_d;
         ext_q  <= ext_d;
      end
   end

   // Serial output changes on the falling edge so the far end samples it cleanly when rising.
   always_ff @(negedge tck or negedge rst_t_n) begin
      if (!rst_t_n) begin
         tdo_q <= 1'b0;
         ten_q <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         ten_q <= ten_d;
      end
   end

   // A disabled test port hands the output pin back to user logic.
   assign tdo         = JTAG_EN ? tdo_q : user_tdo;
   assign tdo_oe      = JTAG_EN ? ten_q : user_tdo_oe;
   assign tms_pull_en = PULL_EN && JTAG_EN;
   assign tdi_pull_en = PULL_EN && JTAG_EN;

   // Update words cross to clk; a full buffer leaves the word pending, retried on each tck.
   bcc_fifo #(
      .W     (UW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .wclk    (tck),
      .wrst_n  (rst_t_n),
      .w_valid (pend_q),
      .w_ready (w_ready),
      .w_data  (upd_q),
      .rclk    (clk),
      .rrst_n  (arst_n),
      .r_valid (f_valid),
      .r_ready (!upd_hold),
      .r_data  (f_data)
   );

   // The registered external test level crosses by two flops; raw decode logic could glitch.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ex1_q <= 1'b0;
         ex2_q <= 1'b0;
      end else begin
         ex1_q <= ext_q;
         ex2_q <= ex1_q;
      end
   end

   // Pads and macrocells follow the core unless external test is active.
   always_comb begin
      ovr_d = (f_valid && !upd_hold) ? f_data : ovr_q;
      out_d = ex2_q ? ovr_q[N_IO-1:0] : core_out;
      oe_d  = ex2_q ? ovr_q[2*N_IO-1:N_IO] : core_oe;
      mc_d  = ex2_q ? ovr_q[UW-1:2*N_IO] : mc_core;
   end

   // System clock registers for the override values and pad drivers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_q <= '0;
         out_q <= '0;
         oe_q  <= '0;
         mc_q  <= '0;
      end else begin
         ovr_q <= ovr_d;
         out_q <= out_d;
         oe_q  <= oe_d;
         mc_q  <= mc_d;
      end
   end
   assign io_out = out_q;
   assign io_oe  = oe_q;
   assign mc_out = mc_q;

   // Five high mode-select edges always reach the reset state.
   sequence s_tms_high;
      tms [*5];
   endsequence
   a_tap_reset : assert property (@(posedge tck) disable iff (!rst_t_n)
      s_tms_high |=> st_q == TLR) else $error("Controller missed reset state.");
   a_tdo_last : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q == SH_DR && bnd && $past(st_q) == SH_DR |-> tdo_q == cap_q[0])
      else $error("Serial output is not the last capture stage.");
   a_shift_in : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q == SH_DR && bnd |=> cap_q[CL-1] == $past(tdi))
      else $error("Serial input did not enter the chain.");
   a_upd_hold : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q != UPD_DR |=> $stable(upd_q)) else $error("Update stage moved while shifting.");
   a_upd_load : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q == UPD_DR && bnd |=> upd_q == $past(cu) && pend_q)
      else $error("Update stage did not load from capture.");
   a_id_cap : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q == CAP_DR && idsel |=> idr_q == ID) else $error("Identification not captured.");
   a_ir_reset : assert property (@(posedge tck) disable iff (!rst_t_n)
      st_q == TLR |=> ir_q == IR_IDCODE) else $error("Reset did not select identification.");
   a_pass_thru : assert property (@(posedge clk) disable iff (!arst_n)
      arst_n && !ex2_q |=> io_out == $past(core_out) && mc_out == $past(mc_core))
      else $error("Functional path not transparent.");
   a_ovr_pins : assert property (@(posedge clk) disable iff (!arst_n)
      ex2_q |=> io_oe == $past(ovr_q[2*N_IO-1:N_IO]))
      else $error("External test did not drive enables.");
endmodule // bcc_chain

// ==== bcc_chain_tb.sv ====
`timescale 1ns/10ps
module bcc_chain_tb;
   import bcc_pkg::*;
   localparam int          NI = 2;
   localparam int          NO = 2;
   localparam int          NM = 2;
   localparam int          NB = NI + 3 * NO + NM;
   // Identification value is arbitrary.
   localparam logic [31:0] TB_ID = 32'h1234_5671;
   logic        clk, arst_n, tck, tms, tdi, tdo, tdo_oe, tms_pull_en, tdi_pull_en;
   logic        upd_hold, tdo_pin;
   logic [1:0]  in_pin, io_in, core_out, core_oe, io_out, io_oe, mc_core, mc_out;
   logic [63:0] d;
   int          fail_count = 0;
   int          n_checks = 0;

   bcc_chain #(.N_IN(NI), .N_IO(NO), .N_MC(NM), .ID(TB_ID)) bcc_chain_i (
      .clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .tms_pull_en(tms_pull_en), .tdi_pull_en(tdi_pull_en),
      .user_tdo(1'b0), .user_tdo_oe(1'b0), .in_pin(in_pin), .io_in(io_in),
      .core_out(core_out), .core_oe(core_oe), .io_out(io_out), .io_oe(io_oe),
      .mc_core(mc_core), .mc_out(mc_out), .upd_hold(upd_hold));

   bcc_jtag_host bcc_jtag_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

   // A released output pin reads inverted, so sampling outside the driven window shows up.
   assign tdo_pin = tdo_oe ? tdo : ~tdo;

   // System clock at 20 MHz.
   always #25 clk = ~clk;

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Chain image that loads the given pad outputs, enables and macrocell values.
   function automatic logic [63:0] mk(input logic [1:0] o, input logic [1:0] e,
                                      input logic [1:0] m);
      return {54'h0, m, e[1], o[1], 1'b0, e[0], o[0], 3'h0};
   endfunction

   // Waits, bounded, for the pads to settle, sampling away from the clock edge.
   task automatic wait_pads(input logic [1:0] o, input logic [1:0] e, input logic [1:0] m);
      int k;
      for (k = 0; k < 60; k++) begin
         @(negedge clk);
         if ({io_out, io_oe, mc_out} === {o, e, m}) break;
      end
      chk({io_out, io_oe, mc_out}, {o, e, m});
      if (k == 60) results();
   endtask

   task automatic t_idcode();
      bcc_jtag_host_i.scan(1'b0, 32, '1, d);
      chk(d, TB_ID);
      chk({tdo_oe, tms_pull_en, tdi_pull_en}, 3'b011);
   endtask

   // Live values reach the chain in chain order; pads stay transparent.
   task automatic t_sample();
      bcc_jtag_host_i.scan(1'b1, 4, IR_SAMPLE, d);
      chk(d[3:0], 4'h1);
      bcc_jtag_host_i.scan(1'b0, NB, mk(2'b10, 2'b11, 2'b01), d);
      chk(d, 10'h3A9);
      wait_pads(2'b01, 2'b10, 2'b11);
   endtask

   // The preloaded word takes over under external test, then a held FIFO fills.
   task automatic t_extest();
      bcc_jtag_host_i.scan(1'b1, 4, IR_EXTEST, d);
      wait_pads(2'b10, 2'b11, 2'b01);
      @(posedge clk);
      upd_hold <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         bcc_jtag_host_i.scan(1'b0, NB, mk(i[1:0], i[2:1], i[3:2]), d);
      end
      @(negedge clk);
      chk({io_out, io_oe, mc_out}, {2'b10, 2'b11, 2'b01});
      @(posedge clk);
      upd_hold <= 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk({io_out, io_oe, mc_out}, {2'b11, 2'b11, 2'b01});
      bcc_jtag_host_i.run(1'b0, 10);
      wait_pads(2'b01, 2'b00, 2'b10);
   endtask

   // Bypass and an unknown code both give a one-bit path that captures zero.
   task automatic t_bypass();
      logic [3:0] codes [2];
      codes = '{IR_BYPASS, 4'h7};
      foreach (codes[c]) begin
         bcc_jtag_host_i.scan(1'b1, 4, codes[c], d);
         bcc_jtag_host_i.scan(1'b0, 8, 8'hA5, d);
         chk(d, 8'h4A);
      end
      wait_pads(2'b01, 2'b10, 2'b11);
   endtask

   // Watchdog against a hung run.
   initial begin
      #3ms;
      fail_count++;
      results();
   end

   // Reset with the test clock running, then the scenarios in turn.
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      upd_hold = 1'b0;
      in_pin = 2'b01;
      io_in = 2'b10;
      core_out = 2'b01;
      core_oe = 2'b10;
      mc_core = 2'b11;
      fork
         bcc_jtag_host_i.run(1'b1, 8);
         repeat (3) @(posedge clk);
      join
      chk({io_out, io_oe, mc_out, tdo, tdo_oe}, 8'h00);
      @(posedge clk);
      arst_n <= 1'b1;
      bcc_jtag_host_i.run(1'b1, 6);
      bcc_jtag_host_i.run(1'b0, 1);
      t_idcode();
      t_sample();
      t_extest();
      t_bypass();
      results();
   end
endmodule // bcc_chain_tb

// ==== bcc_jtag_host.sv ====
`timescale 1ns/10ps
// External test controller; its test clock only runs inside a task and rests low between.
module bcc_jtag_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // Idle levels match the pull-ups, so an unused port stays in reset.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One test clock period; tdo is taken just before the rising edge.
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #7.5;
      q = tdo;
      tck = 1'b1;
      #7.5;
      tck = 1'b0;
   endtask

   task automatic run(input logic m, input int n);
      logic q;
      repeat (n) step(m, 1'b1, q);
   endtask

   // From Run-Test/Idle through one scan, LSB first, then back to idle.
   // The idle cycles at the end let a pending update word reach the crossing.
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], q);
         dout[k] = q;
      end
      step(1'b1, 1'b1, q);
      run(1'b0, 3);
   endtask
endmodule // bcc_jtag_host

// ==== bcc_pkg.sv ====
package bcc_pkg;
   localparam int N_IO_DEF = 96;
   localparam int N_IN_DEF = 4;
   localparam int N_MC_DEF = 96;
   localparam int CELL_CAP = 3;
   localparam int CELL_UPD = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPVAL = 4'h1;
   localparam logic [IR_W-1:0] IR_RST = IR_IDCODE;
   // Identification value is arbitrary; bit 0 is one as the standard needs.
   localparam logic [31:0] ID_DEF = 32'h0A5C_3001;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } bcc_tap_type;
endpackage
